// ===== sbp_pkg.sv
// Purpose: Constants and types for the status register and block protection.
// Assumes: One clock domain; the serial command decoder runs on the same clock.
// Notes: Behaviour list below.
// Behaviour
// - Status register is read and written only through read-status and write-status commands.
// - Bit 7 set with protect pin low makes nonvolatile bits read-only; write ignored.
// - Only driving the protect pin high leaves hardware protection; no command does. Here reset also clears bit 7, which ends it.
// - Bit 7 nonvolatile; 0 default allows writes, 1 disables them with pin low.
// - Bit 5 nonvolatile; 0 default protects from top, 1 from bottom.
// - Protect level on bits 6 and 4:2; nonzero blocks program and erase in region.
// - Bit 1 write-enable latch, cleared at reset, must be set before any write.
// - Bit 0 reads busy during status write, program or erase, else ready.
// - Whole-die erase runs only when all four protect-level bits are zero.
// - Busy bit is always the inverse of the flag ready bit.
// - Code 0 none; 1 to 12 protect 2^(code-1) sectors; 13 to 15 all.
// - 4096 sectors of 64KB addressed linearly up to byte 0FFF FFFFh.
// - Program or erase hitting a protected sector sets flag protection error bit 1.
`default_nettype none
package sbp_pkg;
  localparam int SBP_ADDR_W = 28;
  localparam int SBP_SECTOR_W = 12;
  localparam int SBP_SECTOR_LSB = 16;
  localparam int SBP_LEVEL_W = 4;
  localparam int SBP_LEVEL_ALL = 13;
  localparam int SBP_BIT_SRWD = 7;
  localparam int SBP_BIT_LVL3 = 6;
  localparam int SBP_BIT_BOTTOM = 5;
  localparam int SBP_BIT_LVL_LO = 2;
  localparam int SBP_BIT_WEL = 1;
  localparam int SBP_BIT_BUSY = 0;
  localparam logic SBP_RST_SRWD = 1'h0;
  localparam logic SBP_RST_BOTTOM = 1'h0;
  localparam logic [3:0] SBP_RST_LEVEL = 4'h0;
  localparam logic SBP_RST_WEL = 1'h0;

  typedef enum logic [2:0] {
    SBP_OP_READ_STATUS,
    SBP_OP_WRITE_STATUS,
    SBP_OP_WRITE_ENABLE,
    SBP_OP_WRITE_DISABLE,
    SBP_OP_PROGRAM,
    SBP_OP_ERASE,
    SBP_OP_DIE_ERASE
  } sbp_op_t;

  typedef struct packed {
    logic valid;
    sbp_op_t op;
    logic [SBP_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sbp_cmd_t;

  typedef struct packed {
    logic srwd;
    logic bottom;
    logic [SBP_LEVEL_W-1:0] level;
    logic wel;
    logic busy;
    logic prot_err;
    logic [1:0] wp_sync;
    logic [7:0] rd_data;
    logic rd_valid;
    logic go;
    sbp_op_t go_op;
    logic [SBP_ADDR_W-1:0] go_addr;
    logic refused;
  } sbp_state_t;
endpackage
`default_nettype wire

// ===== sbp_range.sv
// Purpose: Decides whether one 64KB sector lies in the protected region.
// Assumes: Level and direction come straight from status flops.
// Notes: Pure combinational; region size is a power of two by design.
`default_nettype none
module sbp_range
  import sbp_pkg::*;
#(
  parameter int SECTOR_W = SBP_SECTOR_W
) (
  input wire logic [SBP_LEVEL_W-1:0] level,
  input wire logic bottom,
  input wire logic [SECTOR_W-1:0] sector,
  output logic protect
);
  // Refused at elaboration, so a bad width never reaches a netlist
  if (SECTOR_W < 12 || SECTOR_W > 30) begin : g_bad_width
    $error("sbp_range: sector width must hold every 2^(code-1) region");
  end

  logic [SECTOR_W:0] span;
  logic [SECTOR_W:0] top_start;

  always_comb begin
    span = '0;
    top_start = '0;
    protect = 1'b0;
    if (level == '0) begin
      protect = 1'b0;
    end else if (level >= SBP_LEVEL_W'(SBP_LEVEL_ALL)) begin
      protect = 1'b1;
    end else begin
      span = (SECTOR_W+1)'(1) << (level - SBP_LEVEL_W'(1));
      top_start = ((SECTOR_W+1)'(1) << SECTOR_W) - span;
      if (bottom) begin
        protect = {1'b0, sector} < span;
      end else begin
        protect = {1'b0, sector} >= top_start;
      end
    end
  end
endmodule // sbp_range
`default_nettype wire

// ===== sbp_status.sv
// Purpose: Status register, write-enable latch, busy flag and array guard.
// Assumes: Commands arrive decoded, one-cycle valid, on the same clock.
// Notes: Nonvolatile bits are modelled as flops reset to their defaults.
`default_nettype none
module sbp_status
  import sbp_pkg::*;
#(
  parameter int ADDR_W = SBP_ADDR_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire sbp_cmd_t cmd,
  input wire logic array_done,
  input wire logic io_line_two_wp_n,
  input wire logic clear_flags,
  output logic [7:0] status_rdata,
  output logic status_rvalid,
  output logic [7:0] status_live,
  output logic array_go,
  output sbp_op_t array_op,
  output logic [ADDR_W-1:0] array_addr,
  output logic cmd_refused,
  output logic flag_ready,
  output logic flag_prot_err
);
  // Refused at elaboration; the carrier's address width is fixed
  if (ADDR_W != SBP_ADDR_W) begin : g_bad_addr_w
    $error("sbp_status: address width must match the command carrier");
  end

  sbp_state_t state;
  sbp_state_t next_state;
  logic wp_low;
  logic hw_locked;
  logic sector_prot;
  logic [7:0] status_byte;

  sbp_range #(
    .SECTOR_W(SBP_SECTOR_W)
  ) u_range (
    .level(state.level),
    .bottom(state.bottom),
    .sector(cmd.addr[SBP_SECTOR_LSB +: SBP_SECTOR_W]),
    .protect(sector_prot)
  );

  // Pin is asynchronous, so only the second stage is read.
  assign wp_low = ~state.wp_sync[1];
  assign hw_locked = state.srwd & wp_low;

  always_comb begin
    status_byte = '0;
    status_byte[SBP_BIT_SRWD] = state.srwd;
    status_byte[SBP_BIT_LVL3] = state.level[3];
    status_byte[SBP_BIT_BOTTOM] = state.bottom;
    status_byte[SBP_BIT_LVL_LO +: 3] = state.level[2:0];
    status_byte[SBP_BIT_WEL] = state.wel;
    status_byte[SBP_BIT_BUSY] = state.busy;
  end

  always_comb begin
    next_state = state;
    next_state.wp_sync = {state.wp_sync[0], io_line_two_wp_n};
    next_state.rd_valid = 1'b0;
    next_state.go = 1'b0;
    next_state.refused = 1'b0;
    // Array engine reports the end of any nonvolatile cycle.
    if (state.busy && array_done) begin
      next_state.busy = 1'b0;
      next_state.wel = 1'b0;
    end
    if (clear_flags) begin
      next_state.prot_err = 1'b0;
    end
    if (cmd.valid) begin
      unique case (cmd.op)
        SBP_OP_READ_STATUS: begin
          next_state.rd_data = status_byte;
          next_state.rd_valid = 1'b1;
        end
        SBP_OP_WRITE_ENABLE: begin
          if (!state.busy) begin
            next_state.wel = 1'b1;
          end else begin
            next_state.refused = 1'b1;
          end
        end
        SBP_OP_WRITE_DISABLE: begin
          if (!state.busy) begin
            next_state.wel = 1'b0;
          end else begin
            next_state.refused = 1'b1;
          end
        end
        SBP_OP_WRITE_STATUS: begin
          // Lock leaves the latch set so software sees why nothing changed.
          if (state.busy || !state.wel || hw_locked) begin
            next_state.refused = 1'b1;
          end else begin
            next_state.srwd = cmd.wdata[SBP_BIT_SRWD];
            next_state.bottom = cmd.wdata[SBP_BIT_BOTTOM];
            next_state.level = {cmd.wdata[SBP_BIT_LVL3],
                                cmd.wdata[SBP_BIT_LVL_LO +: 3]};
            next_state.busy = 1'b1;
            next_state.go = 1'b1;
            next_state.go_op = cmd.op;
            next_state.go_addr = cmd.addr;
          end
        end
        SBP_OP_PROGRAM, SBP_OP_ERASE: begin
          if (state.busy || !state.wel) begin
            next_state.refused = 1'b1;
          end else if (sector_prot) begin
            next_state.refused = 1'b1;
            next_state.prot_err = 1'b1;
            next_state.wel = 1'b0;
          end else begin
            next_state.busy = 1'b1;
            next_state.go = 1'b1;
            next_state.go_op = cmd.op;
            next_state.go_addr = cmd.addr;
          end
        end
        SBP_OP_DIE_ERASE: begin
          if (state.busy || !state.wel) begin
            next_state.refused = 1'b1;
          end else if (state.level != '0) begin
            next_state.refused = 1'b1;
            next_state.prot_err = 1'b1;
            next_state.wel = 1'b0;
          end else begin
            next_state.busy = 1'b1;
            next_state.go = 1'b1;
            next_state.go_op = cmd.op;
            next_state.go_addr = '0;
          end
        end
        // Spare op code from a faulty decoder is answered, not dropped
        default: begin
          next_state.refused = 1'b1;
        end
      endcase
    end
    // A new protection error outranks a clear in the same cycle.
    if (cmd.valid && next_state.refused && next_state.prot_err) begin
      next_state.prot_err = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '{
        srwd: SBP_RST_SRWD,
        bottom: SBP_RST_BOTTOM,
        level: SBP_RST_LEVEL,
        wel: SBP_RST_WEL,
        busy: 1'b0,
        prot_err: 1'b0,
        wp_sync: 2'h0,
        rd_data: 8'h00,
        rd_valid: 1'b0,
        go: 1'b0,
        go_op: SBP_OP_READ_STATUS,
        go_addr: '0,
        refused: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  assign status_rdata = state.rd_data;
  assign status_rvalid = state.rd_valid;
  assign status_live = status_byte;
  assign array_go = state.go;
  assign array_op = state.go_op;
  assign array_addr = state.go_addr;
  assign cmd_refused = state.refused;
  assign flag_ready = ~state.busy;
  assign flag_prot_err = state.prot_err;
endmodule // sbp_status
`default_nettype wire

// ===== sbp_asserts.sv
// Purpose: Port checks for sbp_status.
// Assumes: One clock domain.
// Notes: Bound at the foot.
`default_nettype none
module sbp_asserts
  import sbp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire sbp_cmd_t cmd,
  input wire logic array_done,
  input wire logic io_line_two_wp_n,
  input wire logic [7:0] status_rdata,
  input wire logic status_rvalid,
  input wire logic [7:0] status_live,
  input wire logic array_go,
  input wire logic cmd_refused,
  input wire logic flag_ready,
  input wire logic flag_prot_err
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence take_s(sbp_op_t o);
    cmd.valid && cmd.op == o;
  endsequence
  read_echo_a: assert property (take_s(SBP_OP_READ_STATUS) |=>
    status_rvalid && status_rdata == $past(status_live)) else $error("read data wrong");
  one_answer_a: assert property (cmd.valid |=>
    $onehot0({status_rvalid, array_go, cmd_refused})) else $error("several answers");
  hw_lock_a: assert property ((!io_line_two_wp_n)[*3] ##0 take_s(SBP_OP_WRITE_STATUS)
    ##0 status_live[7] |=> cmd_refused) else $error("locked write taken");
  ready_inv_a: assert property (flag_ready != status_live[0])
    else $error("ready not inverse of busy");
  die_guard_a: assert property (take_s(SBP_OP_DIE_ERASE)
    ##0 {status_live[6], status_live[4:2]} != 0 |=> !array_go) else $error("die erase run");
  wel_gate_a: assert property (take_s(SBP_OP_PROGRAM) ##0 !status_live[1]
    |=> cmd_refused) else $error("program without latch");
  go_busy_a: assert property (array_go |-> status_live[0])
    else $error("go without busy");
  done_idle_a: assert property (array_done && status_live[0] |=>
    !status_live[0] && !status_live[1]) else $error("busy kept after done");
  prot_flag_a: assert property ($rose(flag_prot_err) |-> cmd_refused)
    else $error("error flag without refusal");
endmodule // sbp_asserts
bind sbp_status sbp_asserts chk (.clock, .rst, .cmd, .array_done, .io_line_two_wp_n,
  .status_rdata, .status_rvalid, .status_live, .array_go, .cmd_refused, .flag_ready,
  .flag_prot_err);
`default_nettype wire

// ===== sbp_engine.sv
// Purpose: Array engine stand-in; each go ends in one done pulse.
// Assumes: Latency set by the bench, 0 gives the quickest answer.
// Notes: One cycle at a time, as the block allows.
`default_nettype none
module sbp_engine (
  input wire logic clock,
  input wire logic rst,
  input wire logic array_go,
  input wire logic [3:0] lat,
  output logic array_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 5'h0;
      array_done <= 1'b0;
    end else begin
      array_done <= cnt == 5'h1;
      if (array_go)
        cnt <= {1'b0, lat} + 5'h1;
      else if (cnt != 5'h0)
        cnt <= cnt - 5'h1;
    end
  end
endmodule // sbp_engine
`default_nettype wire

// ===== sbp_status_bench.sv
// Purpose: Self-checking bench for sbp_status.
// Assumes: 25 MHz clock; random engine latency.
// Notes: Array ends, region edge and random sectors.
`default_nettype none
module sbp_status_bench
  import sbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, done, wp = 1'b1, clr = 1'b0, go, rf, rv, fr, pe;
  logic a_go, a_rf, a_rv;
  sbp_cmd_t cmd = '0;
  logic [7:0] rdata, live;
  logic [3:0] lat = 4'h0;
  logic [27:0] addr;
  sbp_op_t op;
  int error_cnt = 0, total_checks = 0;
  sbp_status dut (.clock, .rst, .cmd, .array_done(done), .io_line_two_wp_n(wp),
    .clear_flags(clr), .status_rdata(rdata), .status_rvalid(rv), .status_live(live),
    .array_go(go), .array_op(op), .array_addr(addr), .cmd_refused(rf), .flag_ready(fr),
    .flag_prot_err(pe));
  sbp_engine eng (.clock, .rst, .array_go(go), .lat, .array_done(done));
  initial forever #20 clock = ~clock;
  task automatic chk(logic [27:0] g, e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic issue(sbp_op_t o, logic [27:0] a, logic [7:0] d);
    @(posedge clock) #1;
    cmd = {1'b1, o, a, d};
    @(posedge clock) #1;
    cmd.valid = 1'b0;
    {a_go, a_rf, a_rv} = {go, rf, rv};
  endtask
  task automatic idle;
    int i;
    for (i = 0; i < 100 && fr !== 1'b1; i++)
      @(posedge clock) #1;
    if (i == 100) begin
      chk(0, 1);
      print_verdict();
    end
  endtask
  task automatic set_status(logic [7:0] d);
    issue(SBP_OP_WRITE_ENABLE, 0, 0);
    issue(SBP_OP_WRITE_STATUS, 0, d);
    idle();
  endtask
  // Exact table form: code gives a power-of-two sector count
  function automatic logic prot(int n, logic b, int s);
    return b ? s < n : s >= 4096 - n;
  endfunction
  initial begin
    int s, c, k, n;
    logic b;
    logic [7:0] d;
    sbp_op_t o;
    void'($urandom(46188));
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    chk(live, 0);
    chk(fr, 1);
    issue(SBP_OP_PROGRAM, 0, 0);
    chk(a_rf, 1);
    for (c = 0; c < 16; c++) begin
      n = c == 0 ? 0 : c > 12 ? 4096 : 1 << (c - 1);
      for (k = 0; k < 2; k++) begin
        b = k[0];
        d = {1'b0, c[3], b, c[2:0], 2'h0};
        lat = 4'($urandom % 9);
        set_status(d);
        chk(live, d);
        issue(SBP_OP_READ_STATUS, 0, 0);
        chk(rdata, d);
        chk(a_rv, 1);
        for (int j = 0; j < 4; j++) begin
          clr = 1'b1;
          @(posedge clock) #1 clr = 1'b0;
          s = j < 2 ? 4095 * j : j == 2 ? (b ? n % 4096 : (8191 - n) % 4096) : $urandom % 4096;
          o = sbp_op_t'(j[0] ? SBP_OP_ERASE : SBP_OP_PROGRAM);
          issue(SBP_OP_WRITE_ENABLE, 0, 0);
          issue(o, {12'(s), 16'h0}, 0);
          chk(a_go, !prot(n, b, s));
          chk(pe, prot(n, b, s));
          if (!prot(n, b, s)) begin
            chk(addr, {12'(s), 16'h0});
            chk(op, o);
          end
          idle();
        end
        issue(SBP_OP_WRITE_ENABLE, 0, 0);
        issue(SBP_OP_DIE_ERASE, 0, 0);
        chk(a_go, c == 0);
        if (c == 0) begin
          chk(addr, 0);
        end
        idle();
      end
    end
    set_status(8'h80);
    wp = 1'b0;
    issue(SBP_OP_WRITE_ENABLE, 0, 0);
    issue(SBP_OP_WRITE_STATUS, 0, 8'h00);
    chk(a_rf, 1);
    chk(live, 8'h82);
    wp = 1'b1;
    repeat (2) @(posedge clock);
    issue(SBP_OP_WRITE_STATUS, 0, 8'h00);
    chk(a_go, 1);
    idle();
    chk(live, 0);
    issue(SBP_OP_WRITE_ENABLE, 0, 0);
    chk(live, 8'h02);
    issue(SBP_OP_WRITE_DISABLE, 0, 0);
    chk(live, 0);
    issue(SBP_OP_WRITE_ENABLE, 0, 0);
    // Mid-run reset must drop the latch again
    rst = 1'b1;
    @(posedge clock) #1 rst = 1'b0;
    chk(live, 0);
    chk(fr, 1);
    print_verdict();
  end
endmodule // sbp_status_bench
`default_nettype wire
